/* File: fwsr_ctrl.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - poll reads use the programmed address
// - erase poll reads use an address inside an erased sector
// - after poll success, one extra read gets all eight valid bits
// - read status twice, compare toggle; unchanged means done
// - toggling with timeout high: recheck, then fail and send reset
// - leaving monitoring restarts the toggle check from the top
// - after timeout seen in polling, read poll bit once more
// - reset command F0 returns bank to read after timeout
// - status reads address the busy bank
module fwsr_ctrl (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // flash bus
    output logic [21:0] F_ADDR,
    output logic [7:0] F_DQ_O,
    output logic F_DQ_OE_N,
    input wire logic [7:0] F_DQ_I,
    output logic F_CE_N,
    output logic F_OE_N,
    output logic F_WE_N,
    input wire logic F_RB_N
);
    typedef enum {ST_IDLE, ST_RD_LOW, ST_RD_END, ST_EVAL, ST_WR_LOW, ST_WR_END} fwsr_st_e;

    typedef struct packed {
        fwsr_st_e st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [21:0] addr;
        logic [7:0] data;
        logic mode;
        logic busy;
        logic done;
        logic fail;
        logic have_first;
        logic to_seen;
        logic final_rd;
        logic [7:0] prev;
        logic [7:0] rdat;
        logic [7:0] cnt;
        logic [7:0] dq_o;
        logic dq_oe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [2:0] rb_sync;
        logic rb;
        logic sect;
    } fwsr_state_s;

    fwsr_state_s s_q;
    fwsr_state_s s_d;

    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
        toggled = a[fwsr_pkg::TOGGLE_BIT] ^ b[fwsr_pkg::TOGGLE_BIT];
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // three-stage sampling; a change counts once stages two and three agree
        s_d.rb_sync = {s_q.rb_sync[1:0], F_RB_N};
        if (s_q.rb_sync[2] == s_q.rb_sync[1]) begin
            s_d.rb = s_q.rb_sync[2];
        end
        // apb slave, answers one cycle after the access phase starts
        if (PSEL && PENABLE && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            if (PWRITE) begin
                case (PADDR)
                    fwsr_pkg::REG_CTRL: begin
                        s_d.mode = PWDATA[fwsr_pkg::CTRL_MODE];
                        if (PWDATA[fwsr_pkg::CTRL_ABORT] && s_q.busy) begin
                            // monitoring given up; a new start restarts from the top
                            s_d.busy = 1'b0;
                        end else if (PWDATA[fwsr_pkg::CTRL_START] && !s_q.busy) begin
                            s_d.busy = 1'b1;
                            s_d.done = 1'b0;
                            s_d.fail = 1'b0;
                            s_d.have_first = 1'b0;
                            s_d.to_seen = 1'b0;
                            s_d.final_rd = 1'b0;
                            s_d.sect = 1'b0;
                        end
                    end
                    fwsr_pkg::REG_ADDR: s_d.addr = PWDATA[21:0];
                    fwsr_pkg::REG_DATA: s_d.data = PWDATA[7:0];
                    fwsr_pkg::REG_STAT, fwsr_pkg::REG_RDAT: ;
                    default: s_d.pslverr = 1'b1;
                endcase
            end else begin
                case (PADDR)
                    fwsr_pkg::REG_CTRL: s_d.prdata = {30'h0, s_q.mode, 1'b0};
                    fwsr_pkg::REG_ADDR: s_d.prdata = {10'h000, s_q.addr};
                    fwsr_pkg::REG_DATA: s_d.prdata = {24'h000000, s_q.data};
                    fwsr_pkg::REG_STAT: s_d.prdata = {27'h0, s_q.sect, s_q.rb, s_q.fail,
                        s_q.done, s_q.busy};
                    fwsr_pkg::REG_RDAT: s_d.prdata = {24'h000000, s_q.rdat};
                    default: s_d.pslverr = 1'b1;
                endcase
            end
        end
        // flash sequencer
        case (s_q.st)
            ST_IDLE: begin
                s_d.ce_n = 1'b1;
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.dq_oe_n = 1'b1;
                if (s_q.busy) begin
                    // first read only after start, so after the final write strobe
                    s_d.st = ST_RD_LOW;
                    s_d.ce_n = 1'b0;
                    s_d.oe_n = 1'b0;
                    s_d.cnt = fwsr_pkg::ACC_CNT;
                end
            end
            ST_RD_LOW: begin
                if (s_q.cnt > 8'h01) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else begin
                    s_d.rdat = F_DQ_I;
                    s_d.ce_n = 1'b1;
                    s_d.oe_n = 1'b1; // each separate read cycle flips the toggle bits
                    s_d.st = ST_RD_END;
                end
            end
            ST_RD_END: s_d.st = ST_EVAL;
            ST_EVAL: begin
                s_d.st = ST_IDLE;
                if (!s_q.busy) begin
                    // monitoring was given up during this read, so its result is dropped
                    s_d.st = ST_IDLE;
                end else if (s_q.final_rd) begin
                    // poll bit may flip before the low bits settle
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end else if (!s_q.mode) begin
                    // poll bit: inverse while programming, 0 while erasing
                    if (s_q.rdat[fwsr_pkg::POLL_BIT] == s_q.data[fwsr_pkg::POLL_BIT]) begin
                        s_d.final_rd = 1'b1;
                    end else if (s_q.to_seen) begin
                        s_d.st = ST_WR_LOW;
                    end else if (s_q.rdat[fwsr_pkg::TIMEOUT_BIT]) begin
                        s_d.to_seen = 1'b1;
                    end
                end else begin
                    s_d.sect = s_q.have_first &&
                        (s_q.rdat[fwsr_pkg::SECTOR_TOGGLE_BIT] ^
                         s_q.prev[fwsr_pkg::SECTOR_TOGGLE_BIT]);
                    s_d.prev = s_q.rdat;
                    s_d.have_first = 1'b1;
                    if (s_q.have_first) begin
                        if (!toggled(s_q.rdat, s_q.prev)) begin
                            s_d.final_rd = 1'b1;
                        end else if (s_q.to_seen) begin
                            s_d.st = ST_WR_LOW;
                        end else if (s_q.rdat[fwsr_pkg::TIMEOUT_BIT]) begin
                            s_d.to_seen = 1'b1;
                        end
                    end
                end
                if (s_d.st == ST_WR_LOW) begin
                    s_d.ce_n = 1'b0;
                    s_d.we_n = 1'b0;
                    s_d.dq_oe_n = 1'b0;
                    s_d.dq_o = fwsr_pkg::CMD_RESET;
                    s_d.cnt = fwsr_pkg::WP_CNT;
                end
            end
            ST_WR_LOW: begin
                if (s_q.cnt > 8'h01) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else begin
                    s_d.we_n = 1'b1;
                    s_d.st = ST_WR_END;
                end
            end
            ST_WR_END: begin
                s_d.ce_n = 1'b1;
                s_d.dq_oe_n = 1'b1;
                s_d.busy = 1'b0;
                s_d.fail = 1'b1;
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.dq_oe_n <= 1'b1;
            s_q.ce_n <= 1'b1;
            s_q.oe_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.rb_sync <= 3'h7;
            s_q.rb <= 1'b1;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, each straight from the state register
    // ---------------------------------------------------------------
    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign F_ADDR = s_q.addr;
    assign F_DQ_O = s_q.dq_o;
    assign F_DQ_OE_N = s_q.dq_oe_n;
    assign F_CE_N = s_q.ce_n;
    assign F_OE_N = s_q.oe_n;
    assign F_WE_N = s_q.we_n;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_RESET_AFTER_FAIL: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CLK_EN && s_q.st == ST_WR_END) |=> s_q.fail && !s_q.busy)
        else $error("fail not flagged after reset command");
    AST_RESET_DATA: assert property (@(posedge CLK) disable iff (!RESET_N)
        !F_WE_N |-> F_DQ_O == fwsr_pkg::CMD_RESET && !F_DQ_OE_N)
        else $error("write strobe without reset data");
    AST_NO_WRITE_READ: assert property (@(posedge CLK) disable iff (!RESET_N)
        !(F_WE_N == 1'b0 && F_OE_N == 1'b0))
        else $error("read and write strobes overlap");
    AST_DONE_NEEDS_EXTRA: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CLK_EN && s_q.st == ST_EVAL && !s_q.final_rd && !s_q.fail) |=> !s_q.done)
        else $error("done without extra read");
    AST_READ_PULSE: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(F_OE_N) && CLK_EN |-> !F_OE_N [*2])
        else $error("read strobe too short");
    AST_TOGGLE_TWO_READS: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CLK_EN && s_q.st == ST_EVAL && s_q.mode && !s_q.have_first && !s_q.final_rd)
        |=> !s_q.final_rd)
        else $error("toggle judged on one read");
    AST_POLL_TIMEOUT_RECHECK: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CLK_EN && s_q.st == ST_EVAL && !s_q.mode && !s_q.to_seen && !s_q.final_rd)
        |=> s_q.st != ST_WR_LOW)
        else $error("reset sent without poll recheck");
    AST_ADDR_STABLE: assert property (@(posedge CLK) disable iff (!RESET_N)
        (!F_OE_N && $past(!F_OE_N)) |-> $stable(F_ADDR))
        else $error("address moved during read");
    // a failure is only ever reported by the end of the reset command write
    AST_FAIL_FROM_WRITE: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(s_q.fail) |-> $past(s_q.st) == ST_WR_END)
        else $error("fail raised outside the reset command");
    // toggle mode never gives up before a timeout was seen on an earlier read
    AST_TOGGLE_TIMEOUT_RECHECK: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CLK_EN && s_q.st == ST_EVAL && s_q.mode && !s_q.to_seen) |=> s_q.st != ST_WR_LOW)
        else $error("reset sent without toggle recheck");
    AST_DONE_AFTER_FINAL: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(s_q.done) |-> $past(s_q.final_rd))
        else $error("done raised without the extra read");
    // a restart must not inherit the pair or sector result of the previous run
    AST_START_CLEARS_SECT: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(s_q.busy) |-> !s_q.sect && !s_q.have_first)
        else $error("stale result after start");
    AST_WRITE_PULSE: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(F_WE_N) |-> !F_WE_N [*7])
        else $error("reset command strobe too short");
    AST_STROBE_UNDER_SELECT: assert property (@(posedge CLK) disable iff (!RESET_N)
        (!F_OE_N || !F_WE_N) |-> !F_CE_N)
        else $error("strobe without chip select");
endmodule

/* File: fwsr_pkg.sv */
package fwsr_pkg;
    // ---------------------------------------------------------------
    // register map of the controller (apb, word aligned)
    // ---------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_DATA = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00C;
    localparam logic [11:0] REG_RDAT = 12'h010;
    // ctrl fields
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_ABORT = 2;
    // stat fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_FAIL = 2;
    localparam int STAT_RB = 3;
    localparam int STAT_SECT = 4;
    // device status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int SECTOR_TOGGLE_BIT = 2;
    // reset command data
    localparam logic [7:0] CMD_RESET = 8'hF0;
    // flash bus timing, 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 35;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] ACC_CNT = 8'(ACC_CYC);
    localparam logic [7:0] WP_CNT = 8'(WP_CYC);
endpackage

/* File: fwsr_flash_model.sv */
`timescale 1ns/1ps
module fwsr_flash_model (
    // flash bus from the controller
    input wire logic [7:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [21:0] addr,
    // status side
    output logic [7:0] dq_out,
    output logic rb_n
);
    logic busy = 1'b0;
    logic erase = 1'b0;
    logic stuck = 1'b0;
    logic susp = 1'b0;
    logic tout = 1'b0;
    logic tog = 1'b0;
    logic tog2 = 1'b0;
    logic [7:0] data = 8'hFF;
    logic [7:0] last = 8'h00;
    logic [7:0] stat;
    logic [21:0] va = 22'h000000;
    int left = 0;
    int resets = 0;
    wire rd = ~ce_n & ~oe_n;
    // status only at the address under way; any other address reads array data
    wire here = (addr == va);
    // called as if the last command write strobe had just risen; a protected or
    // partly protected target, or a program in erase suspend, is a run of n status reads
    task automatic arm(input logic e, input logic s, input int n, input logic [7:0] d,
        input logic [21:0] a);
        erase = e;
        stuck = s;
        left = n;
        data = d;
        va = a;
        susp = 1'b0;
        tout = 1'b0;
        busy = 1'b1;
    endtask
    // erase suspend: the bank still shows status, but the operation no longer runs
    task automatic suspend;
        susp = 1'b1;
    endtask
    always_comb begin
        stat = {erase ? 1'b0 : ~data[7], tog, tout, 2'b00, tog2, 2'b00};
        // bit 7 turns to data one read early while the low bits still show status
        if (left == 1 && !stuck) stat[7] = data[7];
        if (susp) stat[7] = 1'b1;
    end
    // a released bus shows the inverse of the last byte, never a stale copy
    assign dq_out = rd ? ((busy && here) ? stat : data) : ~last;
    assign rb_n = (busy && !susp) ? 1'b0 : 1'b1;
    // a read ends on whichever strobe rises first
    always @(negedge rd) begin
        last = (busy && here) ? stat : data;
        if (busy) begin
            if (!susp) tog = ~tog;
            tog2 = tog2 ^ (erase & here);
            if (here && !susp && left > 0) left = left - 1;
            if (left == 0 && stuck) tout = 1'b1;
            if (left == 0 && !stuck) busy = 1'b0;
        end
    end
    always @(posedge we_n) begin
        if (ce_n === 1'b0 && dq_in === 8'hF0) begin
            busy = 1'b0;
            tout = 1'b0;
            resets++;
        end
    end
endmodule

/* File: fwsr_ctrl_tb.sv */
`timescale 1ns/1ps
module fwsr_ctrl_tb;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic CLK_EN = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [21:0] F_ADDR;
    logic [7:0] F_DQ_O;
    logic [7:0] F_DQ_I;
    logic F_DQ_OE_N;
    logic F_CE_N;
    logic F_OE_N;
    logic F_WE_N;
    logic F_RB_N;
    int failures = 0;
    int total_checks = 0;
    int seed = 10519;
    int rst0;
    logic [31:0] rdat;
    logic err;
    logic [31:0] r;
    logic st;
    always #2.5 CLK = ~CLK;
    fwsr_ctrl uut (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .F_ADDR(F_ADDR),
        .F_DQ_O(F_DQ_O), .F_DQ_OE_N(F_DQ_OE_N), .F_DQ_I(F_DQ_I), .F_CE_N(F_CE_N),
        .F_OE_N(F_OE_N), .F_WE_N(F_WE_N), .F_RB_N(F_RB_N));
    fwsr_flash_model mdl (.dq_in(F_DQ_O), .ce_n(F_CE_N), .oe_n(F_OE_N), .we_n(F_WE_N),
        .addr(F_ADDR),
        .dq_out(F_DQ_I), .rb_n(F_RB_N));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // wait for the rising edge at which ready is high; only the watchdog ends it
        do @(posedge CLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // idle status: ready line high plus done or fail
    function automatic logic [31:0] exp_stat(input logic fail);
        return fail ? 32'h0000000C : 32'h0000000A;
    endfunction
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            st = (i % 4 == 3);
            if (r[0]) r[23:16] = 8'hFF;
            rst0 = mdl.resets;
            mdl.arm(r[0], st, (i < 2) ? 1 : (i == 5) ? 4 : 1 + int'(r[9:8]), r[23:16],
                r[31:10]);
            apb(1'b1, fwsr_pkg::REG_ADDR, {10'h0, r[31:10]});
            apb(1'b1, fwsr_pkg::REG_DATA, {24'h0, r[23:16]});
            apb(1'b1, fwsr_pkg::REG_CTRL, {30'h0, r[1], 1'b1});
            if (i == 5) begin
                // give up monitoring mid-read, then start over from the first read
                apb(1'b1, fwsr_pkg::REG_CTRL, {29'h0, 1'b1, r[1], 1'b0});
                apb(1'b0, fwsr_pkg::REG_STAT, 32'h0);
                chk(rdat & 32'h7, 32'h0);
                repeat (20) @(posedge CLK);
                apb(1'b1, fwsr_pkg::REG_CTRL, {30'h0, r[1], 1'b1});
            end
            apb(1'b0, fwsr_pkg::REG_CTRL, 32'h0);
            chk(rdat & 32'h1, 32'h0);
            apb(1'b0, fwsr_pkg::REG_STAT, 32'h0);
            chk(rdat & 32'h9, 32'h1);
            do apb(1'b0, fwsr_pkg::REG_STAT, 32'h0); while (rdat[0] !== 1'b0);
            apb(1'b0, fwsr_pkg::REG_STAT, 32'h0);
            chk(rdat & 32'hF, exp_stat(st));
            chk(32'(mdl.resets - rst0), {31'h0, st});
            chk({10'h0, F_ADDR}, {10'h0, r[31:10]});
            apb(1'b0, fwsr_pkg::REG_RDAT, 32'h0);
            if (!st) chk(rdat & 32'hFF, {24'h0, r[23:16]});
        end
        // erase already suspended: status stands still, the sector bit still runs
        for (int m = 0; m < 2; m++) begin
            r = $random(seed);
            mdl.arm(1'b1, 1'b0, 8, 8'hFF, r[31:10]);
            mdl.suspend();
            apb(1'b1, fwsr_pkg::REG_ADDR, {10'h0, r[31:10]});
            apb(1'b1, fwsr_pkg::REG_DATA, 32'h000000FF);
            apb(1'b1, fwsr_pkg::REG_CTRL, {30'h0, m[0], 1'b1});
            do apb(1'b0, fwsr_pkg::REG_STAT, 32'h0); while (rdat[0] !== 1'b0);
            apb(1'b0, fwsr_pkg::REG_STAT, 32'h0);
            chk(rdat & 32'h1F, m[0] ? 32'h0000001A : 32'h0000000A);
            apb(1'b0, fwsr_pkg::REG_RDAT, 32'h0);
            chk(rdat & 32'hA0, 32'h00000080);
        end
        summarize;
    end
    initial begin
        #200000;
        failures++;
        summarize;
    end
endmodule
